// File: logic/nvb_ctrl.sv
// Byte access controller for the 512-byte data nonvolatile array
//
// What this block does
// - Address register selects one of 512 bytes linearly, 0 to 511.
// - Address bits 15..9 and control bits 7..6 always read zero.
// - Data register holds byte to program, and receives the byte read.
// - Mode field: 00 atomic, 01 erase only, 10 write only, 11 reserved.
// - Mode field writes are ignored while write strobe is set.
// - Reset clears mode field to 00 unless programming is in progress.
// - Ready interrupt is a level while enabled, global enable set, strobe clear.
// - Write strobe starts programming only within four cycles of master enable.
// - Master write enable clears itself four cycles after being set.
// - No data programming starts while processor programs the flash.
// - Hardware clears write strobe when programming time has elapsed.
// - Setting write strobe stalls the processor for two cycles.
// - Read strobe fetches the byte at once and stalls four cycles.
// - While programming, reads are refused and the address is frozen.
// - Atomic programming counts 26,368 calibrated oscillator cycles, split modes 13,959.
// - Reset during programming lets the operation finish.
module nvb_ctrl
   import nvb_pkg::*;
#(
   parameter int PROG_CYC_ATOMIC = NVB_PROG_RC_CYC,
   parameter int PROG_CYC_SPLIT  = NVB_PROG_RC_CYC_SPLIT,
   parameter int CNT_W           = 15
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         srst_i,
   // Processor I/O port
   input  wire nvb_io_req_t  io_i,
   output logic [7:0]        io_rdata_o,
   // Processor status and flash programming interlock
   input  wire logic         gie_i,
   input  wire logic         flash_self_program_enable_i,
   output logic              cpu_stall_o,
   output logic              irq_o,
   // Calibrated oscillator pin
   input  wire logic         rc_osc_i,
   // Array macro
   output nvb_arr_cmd_t      arr_o,
   input  wire logic [7:0]   arr_rdata_i
);

   // ***************************************************************
   // Elaboration checks
   // ***************************************************************
   if (PROG_CYC_ATOMIC < 1 || PROG_CYC_ATOMIC >= (1 << CNT_W) ||
       PROG_CYC_SPLIT < 1 || PROG_CYC_SPLIT >= (1 << CNT_W)) begin : g_chk
      $error("nvb_ctrl: programming counts do not fit the timer width");
   end

   // Program state along a two-code Gray path
   typedef enum logic [1:0] {
      NVB_ST_IDLE = 2'b00,
      NVB_ST_PROG = 2'b01
   } nvb_state_t;

   nvb_state_t       state;
   nvb_mode_t        prog_mode, mode_in;
   logic [8:0]       nv_addr_reg;
   logic [7:0]       nv_data_reg, prog_wdata;
   logic [2:0]       mwe_cnt, stall_cnt, next_stall_cnt;
   logic [CNT_W-1:0] tmr_target;
   logic             ready_irq_enable, master_write_enable, write_strobe, read_strobe;
   logic             prog_erase, prog_write, tmr_done;
   logic             wr_addr_lo, wr_addr_hi, wr_data, wr_ctrl, mwe_set, start_ok, rd_req;
   // All assertions below share this clock and are off during reset
   default clocking cb_asrt @(posedge clk_i); endclocking
   default disable iff (srst_i);

   // ***************************************************************
   // Decode helpers
   // ***************************************************************
   function automatic logic reg_wr(input nvb_io_req_t req, input logic [1:0] sel);
      return req.wr && (req.sel == sel);
   endfunction

   function automatic logic [CNT_W-1:0] prog_cycles(input nvb_mode_t m);
      return (m == NVB_PM_ATOMIC) ? CNT_W'(PROG_CYC_ATOMIC) : CNT_W'(PROG_CYC_SPLIT);
   endfunction

   assign wr_addr_lo = reg_wr(io_i, NVB_REG_ADDR_LO);
   assign wr_addr_hi = reg_wr(io_i, NVB_REG_ADDR_HI);
   assign wr_data    = reg_wr(io_i, NVB_REG_DATA);
   assign wr_ctrl    = reg_wr(io_i, NVB_REG_CTRL);
   assign mode_in    = nvb_mode_t'(io_i.wdata[NVB_CTRL_PM_MSB:NVB_CTRL_PM_LSB]);

   // Master enable is taken only with the strobe written as zero
   assign mwe_set = wr_ctrl && io_i.wdata[NVB_CTRL_MWE_BIT] && !io_i.wdata[NVB_CTRL_WS_BIT];
   // Start needs an open window, an idle array and an idle flash
   assign start_ok = wr_ctrl && io_i.wdata[NVB_CTRL_WS_BIT] && master_write_enable
                     && !write_strobe && !flash_self_program_enable_i
                     && (mode_in != NVB_PM_RSVD);
   // Reads are refused while programming
   assign rd_req = wr_ctrl && io_i.wdata[NVB_CTRL_RD_BIT] && (state == NVB_ST_IDLE);
   // Target taken from the mode written together with the strobe
   assign tmr_target = prog_cycles(mode_in);

   // ***************************************************************
   // Programming timer
   // ***************************************************************
   nvb_prog_timer #(.CNT_W (CNT_W)) u_timer (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .rc_osc_i  (rc_osc_i),
      .start_i   (start_ok),
      .target_i  (tmr_target),
      .done_o    (tmr_done),
      .running_o ()
   );

   // ***************************************************************
   // Programming state; reset is ignored while the write strobe is set
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (write_strobe) begin
         if (tmr_done) begin
            write_strobe <= 1'b0;
            state        <= NVB_ST_IDLE;
            prog_erase   <= 1'b0;
            prog_write   <= 1'b0;
         end
      end else if (srst_i) begin
         write_strobe <= 1'b0;
         state        <= NVB_ST_IDLE;
         prog_erase   <= 1'b0;
         prog_write   <= 1'b0;
         prog_wdata   <= NVB_DATA_RESET;
      end else if (start_ok) begin
         write_strobe <= 1'b1;
         state        <= NVB_ST_PROG;
         prog_erase   <= (mode_in != NVB_PM_WRITE);
         prog_write   <= (mode_in != NVB_PM_ERASE);
         prog_wdata   <= nv_data_reg;
      end
   end

   // Mode field: frozen while busy, which also shields it from reset
   always_ff @(posedge clk_i) begin
      if (write_strobe) begin
         prog_mode <= prog_mode;
      end else if (srst_i) begin
         prog_mode <= NVB_PM_ATOMIC;
      end else if (wr_ctrl) begin
         prog_mode <= mode_in;
      end
   end

   // Address: frozen while busy so a reset cannot retarget the write
   always_ff @(posedge clk_i) begin
      if (write_strobe) begin
         nv_addr_reg <= nv_addr_reg;
      end else if (srst_i) begin
         nv_addr_reg <= NVB_ADDR_RESET;
      end else if (wr_addr_lo) begin
         nv_addr_reg[7:0] <= io_i.wdata;
      end else if (wr_addr_hi) begin
         nv_addr_reg[8] <= io_i.wdata[0];
      end
   end

   // Data register: loaded by software or by a finished read
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         nv_data_reg <= NVB_DATA_RESET;
      end else if (read_strobe) begin
         nv_data_reg <= arr_rdata_i;
      end else if (wr_data) begin
         nv_data_reg <= io_i.wdata;
      end
   end

   // Master enable window; a rewrite restarts the four cycles
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         master_write_enable <= 1'b0;
         mwe_cnt             <= 3'h0;
      end else if (mwe_set) begin
         master_write_enable <= 1'b1;
         mwe_cnt             <= 3'(NVB_MWE_WIN_CYC - 1);
      end else if (master_write_enable) begin
         if (mwe_cnt == 3'h0) begin
            master_write_enable <= 1'b0;
         end else begin
            mwe_cnt <= mwe_cnt - 3'h1;
         end
      end
   end

   // Interrupt enable and the one-cycle read strobe
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ready_irq_enable <= 1'b0;
         read_strobe      <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ready_irq_enable <= io_i.wdata[NVB_CTRL_RIE_BIT];
         end
         read_strobe <= rd_req;
      end
   end

   // ***************************************************************
   // Processor stall
   // ***************************************************************
   always_comb begin
      if (start_ok) begin
         next_stall_cnt = 3'(NVB_WR_STALL_CYC);
      end else if (rd_req) begin
         next_stall_cnt = 3'(NVB_RD_STALL_CYC);
      end else begin
         next_stall_cnt = (stall_cnt != 3'h0) ? stall_cnt - 3'h1 : 3'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         stall_cnt   <= 3'h0;
         cpu_stall_o <= 1'b0;
      end else begin
         stall_cnt   <= next_stall_cnt;
         cpu_stall_o <= (next_stall_cnt != 3'h0);
      end
   end

   // Level interrupt; registered so the output comes from a flop
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= ready_irq_enable && gie_i && !write_strobe;
      end
   end

   // ***************************************************************
   // Register read-back, one cycle after the read request
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         io_rdata_o <= 8'h00;
      end else if (io_i.rd) begin
         unique case (io_i.sel)
            NVB_REG_ADDR_LO: io_rdata_o <= nv_addr_reg[7:0];
            NVB_REG_ADDR_HI: io_rdata_o <= {7'h00, nv_addr_reg[8]};
            NVB_REG_DATA:    io_rdata_o <= nv_data_reg;
            NVB_REG_CTRL:    io_rdata_o <= {2'h0, prog_mode, ready_irq_enable,
                                            master_write_enable, write_strobe,
                                            read_strobe};
         endcase
      end
   end

   // Array command, every field straight from a flop
   assign arr_o = '{addr:  nv_addr_reg,
                    wdata: prog_wdata,
                    rd:    read_strobe,
                    erase: prog_erase,
                    prog:  prog_write};

   // ***************************************************************
   // Assertions
   // ***************************************************************
   sequence s_rd_ctrl;
      io_i.rd && io_i.sel == NVB_REG_CTRL;
   endsequence
   property p_ctrl_res_zero;
      s_rd_ctrl |=> io_rdata_o[7:6] == 2'h0;
   endproperty
   a_ctrl_res_zero: assert property (p_ctrl_res_zero)
      else $error("reserved control bits read non-zero");
   property p_addr_hi_zero;
      (io_i.rd && io_i.sel == NVB_REG_ADDR_HI) |=> io_rdata_o[7:1] == 7'h00;
   endproperty
   a_addr_hi_zero: assert property (p_addr_hi_zero)
      else $error("reserved address bits read non-zero");
   sequence s_mwe_quiet;
      mwe_set ##1 (!mwe_set) [*4];
   endsequence
   property p_mwe_expire;
      s_mwe_quiet |=> !master_write_enable;
   endproperty
   a_mwe_expire: assert property (p_mwe_expire)
      else $error("master write enable outlived its window");
   property p_mwe_hold;
      mwe_set |=> master_write_enable [*4];
   endproperty
   a_mwe_hold: assert property (p_mwe_hold)
      else $error("master write enable dropped early");
   property p_start_guard;
      $rose(write_strobe) |-> $past(master_write_enable)
                              && !$past(flash_self_program_enable_i);
   endproperty
   a_start_guard: assert property (p_start_guard)
      else $error("write started without open window or with flash busy");
   property p_mode_frozen;
      (write_strobe && $past(write_strobe)) |-> $stable(prog_mode)
                                                && $stable(nv_addr_reg);
   endproperty
   a_mode_frozen: assert property (p_mode_frozen)
      else $error("mode or address changed while programming");
   property p_irq_level;
      (ready_irq_enable && gie_i && !write_strobe) [*2] |-> irq_o;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("ready interrupt missing");
   property p_wr_stall;
      $rose(write_strobe) |-> cpu_stall_o [*2] ##1 !cpu_stall_o;
   endproperty
   a_wr_stall: assert property (p_wr_stall)
      else $error("write stall not two cycles");
   property p_rd_stall;
      arr_o.rd |-> cpu_stall_o [*4] ##1 !cpu_stall_o;
   endproperty
   a_rd_stall: assert property (p_rd_stall)
      else $error("read stall not four cycles");
   property p_rd_refused;
      (write_strobe && wr_ctrl && io_i.wdata[NVB_CTRL_RD_BIT]) |=> !arr_o.rd;
   endproperty
   a_rd_refused: assert property (p_rd_refused)
      else $error("read accepted while programming");
   property p_done_clears;
      (tmr_done && write_strobe) |=> !write_strobe ##1 !arr_o.prog;
   endproperty
   a_done_clears: assert property (p_done_clears)
      else $error("write strobe not cleared at end of programming");
   property p_rd_pulse;
      arr_o.rd |=> !arr_o.rd;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe longer than one cycle");

endmodule // nvb_ctrl

// File: logic/nvb_pkg.sv
// Package: register map, field layout, modes and timing of the byte access controller
package nvb_pkg;

   // ***************************************************************
   // Array geometry
   // ***************************************************************
   localparam int NVB_DEPTH  = 512;
   localparam int NVB_ADDR_W = 9;
   localparam int NVB_DATA_W = 8;

   // ***************************************************************
   // Register selects on the processor I/O port
   // ***************************************************************
   localparam logic [1:0] NVB_REG_ADDR_LO = 2'h0;
   localparam logic [1:0] NVB_REG_ADDR_HI = 2'h1;
   localparam logic [1:0] NVB_REG_DATA    = 2'h2;
   localparam logic [1:0] NVB_REG_CTRL    = 2'h3;

   // ***************************************************************
   // Control register field positions
   // ***************************************************************
   localparam int NVB_CTRL_RD_BIT  = 0;
   localparam int NVB_CTRL_WS_BIT  = 1;
   localparam int NVB_CTRL_MWE_BIT = 2;
   localparam int NVB_CTRL_RIE_BIT = 3;
   localparam int NVB_CTRL_PM_LSB  = 4;
   localparam int NVB_CTRL_PM_MSB  = 5;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] NVB_DATA_RESET = 8'h00;
   localparam logic [8:0] NVB_ADDR_RESET = 9'h000;

   // Programming mode field
   typedef enum logic [1:0] {
      NVB_PM_ATOMIC = 2'h0,
      NVB_PM_ERASE  = 2'h1,
      NVB_PM_WRITE  = 2'h2,
      NVB_PM_RSVD   = 2'h3
   } nvb_mode_t;

   // ***************************************************************
   // Timing: CPU clock cycles, oscillator cycles, microseconds and clock rate
   // ***************************************************************
   localparam int NVB_CLK_HZ         = 50_000_000;
   localparam int NVB_MWE_WIN_CYC    = 4;
   localparam int NVB_WR_STALL_CYC   = 2;
   localparam int NVB_RD_STALL_CYC   = 4;
   localparam int NVB_PROG_ATOMIC_US = 3400;
   localparam int NVB_PROG_SPLIT_US  = 1800;
   localparam int NVB_PROG_RC_CYC    = 26368;
   // Split modes scale the atomic count by the ratio of their times
   localparam int NVB_PROG_RC_CYC_SPLIT =
      (NVB_PROG_RC_CYC * NVB_PROG_SPLIT_US) / NVB_PROG_ATOMIC_US;

   // Processor I/O request, same clock as the block
   typedef struct packed {
      logic [1:0] sel;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } nvb_io_req_t;

   // Command to the array macro
   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] wdata;
      logic       rd;
      logic       erase;
      logic       prog;
   } nvb_arr_cmd_t;

endpackage : nvb_pkg

// File: logic/nvb_prog_timer.sv
// Programming timer counting cycles of the calibrated RC oscillator
module nvb_prog_timer
   import nvb_pkg::*;
#(
   parameter int CNT_W = 15
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   // Oscillator pin, asynchronous to clk_i
   input  wire logic             rc_osc_i,
   // Control
   input  wire logic             start_i,
   input  wire logic [CNT_W-1:0] target_i,
   // Status
   output logic                  done_o,
   output logic                  running_o
);

   logic             osc_meta;
   logic             osc_sync;
   logic             osc_prev;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] target;
   logic             osc_rise;

   // ***************************************************************
   // Oscillator synchroniser
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      osc_meta <= rc_osc_i;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
   end

   assign osc_rise = osc_sync & ~osc_prev;

   // Counter keeps running through reset so a started write completes
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (running_o) begin
         if (osc_rise) begin
            if (cnt == target - CNT_W'(1)) begin
               running_o <= 1'b0;
               done_o    <= 1'b1;
            end else begin
               cnt <= cnt + CNT_W'(1);
            end
         end
      end else if (srst_i) begin
         running_o <= 1'b0;
         cnt       <= '0;
         target    <= '0;
      end else if (start_i) begin
         running_o <= 1'b1;
         cnt       <= '0;
         target    <= target_i;
      end
   end

endmodule // nvb_prog_timer

// File: verification/nvb_arr_model.sv
// Behavioural model of the byte array behind the access controller
module nvb_arr_model
   import nvb_pkg::*;
(
   // Clock
   input  wire logic         clk_i,
   // Command from the controller
   input  wire nvb_arr_cmd_t arr_i,
   // Read data back
   output logic [7:0]        rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [NVB_DEPTH];
   logic       busy_q;
   logic [1:0] kind_q;

   // Array all zero at start of run
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
   end

   // Cell changes only when the request drops, as a real cell would
   always @(posedge clk_i) begin
      busy_q <= arr_i.erase | arr_i.prog;
      kind_q <= {arr_i.erase, arr_i.prog};
      if (busy_q && !(arr_i.erase | arr_i.prog)) begin
         case (kind_q)
            2'h3: mem[arr_i.addr] <= arr_i.wdata;
            2'h2: mem[arr_i.addr] <= 8'hff;
            default: mem[arr_i.addr] <= mem[arr_i.addr] & arr_i.wdata;
         endcase
      end
   end

   // Outside the strobe the data is garbage, never the stored byte
   assign rdata_o = arr_i.rd ? mem[arr_i.addr] : ~mem[arr_i.addr];
endmodule // nvb_arr_model

// File: verification/nvb_ctrl_bench.sv
// Self-checking bench for the byte access controller
module nvb_ctrl_bench
   import nvb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int OSC_NS = 70;
   logic         clk_i, srst_i, gie, fsp, rc_osc;
   nvb_io_req_t  io;
   logic [7:0]   io_rdata_o, rdata, q, n;
   logic         cpu_stall_o, irq_o;
   nvb_arr_cmd_t arr_o;
   int           error_cnt = 0;
   int           num_checks = 0;
   time          t0;

   // ********************
   // Clocks and instances
   // ********************
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Oscillator free-running, unrelated in phase to clk_i
   initial begin
      rc_osc = 1'b0;
      forever #35 rc_osc = ~rc_osc;
   end

   nvb_ctrl #(.PROG_CYC_ATOMIC(8), .PROG_CYC_SPLIT(4)) u_dut (
      .clk_i(clk_i), .srst_i(srst_i), .io_i(io), .io_rdata_o(io_rdata_o),
      .gie_i(gie), .flash_self_program_enable_i(fsp), .cpu_stall_o(cpu_stall_o),
      .irq_o(irq_o), .rc_osc_i(rc_osc), .arr_o(arr_o), .arr_rdata_i(rdata));
   nvb_arr_model u_arr (.clk_i(clk_i), .arr_i(arr_o), .rdata_o(rdata));

   // ********************
   // Shared tasks
   // ********************
   task automatic close_out();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // A wait that runs out ends the run as a mismatch
   task automatic hang();
      chk(8'hee, 8'h00);
      close_out();
   endtask

   // Requests are never issued into a stall
   task automatic wait_free();
      int k;
      k = 0;
      while (cpu_stall_o !== 1'b0) begin
         @(negedge clk_i);
         k++;
         if (k > 16) hang();
      end
   endtask

   task automatic wr_reg(input logic [1:0] s, input logic [7:0] d);
      @(negedge clk_i);
      wait_free();
      io = '{sel: s, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge clk_i);
      io.wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [1:0] s, output logic [7:0] v);
      @(negedge clk_i);
      wait_free();
      io = '{sel: s, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge clk_i);
      io.rd = 1'b0;
      v = io_rdata_o;
   endtask

   // Counts the stall cycles seen from the current falling edge
   task automatic count_stall();
      n = 8'h00;
      while (cpu_stall_o === 1'b1) begin
         n++;
         @(negedge clk_i);
         if (n > 8'd16) hang();
      end
   endtask

   // Polls the strobe bit; bounded so a stuck strobe cannot hang the run
   task automatic wait_idle();
      int k;
      k = 0;
      rd_reg(NVB_REG_CTRL, q);
      while (q[NVB_CTRL_WS_BIT] !== 1'b0) begin
         k++;
         if (k > 200) hang();
         rd_reg(NVB_REG_CTRL, q);
      end
   endtask

   task automatic prog(input logic [7:0] a, input logic [7:0] d, input nvb_mode_t m,
                       input int gap, input logic rie);
      wait_idle();
      wr_reg(NVB_REG_ADDR_LO, a);
      wr_reg(NVB_REG_ADDR_HI, 8'h00);
      wr_reg(NVB_REG_DATA, d);
      wr_reg(NVB_REG_CTRL, {2'h0, m, rie, 3'h4});
      repeat (gap) @(negedge clk_i);
      wr_reg(NVB_REG_CTRL, {2'h0, m, rie, 3'h2});
   endtask

   task automatic rd_back(input logic [7:0] a, input logic [7:0] exp);
      wr_reg(NVB_REG_ADDR_LO, a);
      wr_reg(NVB_REG_CTRL, 8'h01);
      chk({7'h0, arr_o.rd}, 8'h01);
      count_stall();
      chk(n, 8'd4);
      rd_reg(NVB_REG_CTRL, q);
      chk(q & 8'h01, 8'h00);
      rd_reg(NVB_REG_DATA, q);
      chk(q, exp);
   endtask

   // ********************
   // Scenarios
   // ********************
   task automatic t_reset_vals();
      rd_reg(NVB_REG_DATA, q);
      chk(q, NVB_DATA_RESET);
      rd_reg(NVB_REG_CTRL, q);
      chk(q, 8'h00);
      wr_reg(NVB_REG_ADDR_HI, 8'hfe);
      rd_reg(NVB_REG_ADDR_HI, q);
      chk(q, 8'h00);
      wr_reg(NVB_REG_CTRL, 8'hc0);
      rd_reg(NVB_REG_CTRL, q);
      chk(q, 8'h00);
   endtask

   // Enable seen at t+2 and t+4, gone by t+6; strobe at t+5 is late
   task automatic t_window();
      wr_reg(NVB_REG_CTRL, 8'h04);
      rd_reg(NVB_REG_CTRL, q);
      chk(q, 8'h04);
      rd_reg(NVB_REG_CTRL, q);
      chk(q, 8'h04);
      rd_reg(NVB_REG_CTRL, q);
      chk(q, 8'h00);
      prog(8'h10, 8'h77, NVB_PM_ATOMIC, 3, 1'b0);
      rd_reg(NVB_REG_CTRL, q);
      chk(q & 8'h02, 8'h00);
   endtask

   task automatic t_atomic();
      prog(8'h5a, 8'ha5, NVB_PM_ATOMIC, 2, 1'b1);
      t0 = $time;
      chk({6'h0, arr_o.erase, arr_o.prog}, 8'h03);
      count_stall();
      chk(n, 8'd2);
      gie = 1'b1;
      @(negedge clk_i);
      chk({7'h0, irq_o}, 8'h00);
      wr_reg(NVB_REG_ADDR_LO, 8'h11);
      wr_reg(NVB_REG_CTRL, 8'h38);
      wr_reg(NVB_REG_CTRL, 8'h09);
      count_stall();
      chk(n, 8'd0);
      rd_reg(NVB_REG_ADDR_LO, q);
      chk(q, 8'h5a);
      rd_reg(NVB_REG_CTRL, q);
      chk(q, 8'h0a);
      wait_idle();
      // First counted edge may follow the start at once: eight edges span seven periods
      chk({7'h0, ($time - t0) >= 7 * OSC_NS}, 8'h01);
      chk({7'h0, ($time - t0) <= 12 * OSC_NS}, 8'h01);
      chk({7'h0, irq_o}, 8'h01);
      gie = 1'b0;
      @(negedge clk_i);
      chk({7'h0, irq_o}, 8'h00);
      gie = 1'b1;
      wr_reg(NVB_REG_CTRL, 8'h00);
      @(negedge clk_i);
      chk({7'h0, irq_o}, 8'h00);
      gie = 1'b0;
      rd_back(8'h5a, 8'ha5);
   endtask

   task automatic t_modes();
      prog(8'hff, 8'h00, NVB_PM_ERASE, 0, 1'b0);
      chk({6'h0, arr_o.erase, arr_o.prog}, 8'h02);
      wait_idle();
      rd_back(8'hff, 8'hff);
      prog(8'hff, 8'h3c, NVB_PM_WRITE, 1, 1'b0);
      chk({6'h0, arr_o.erase, arr_o.prog}, 8'h01);
      wait_idle();
      rd_back(8'hff, 8'h3c);
      prog(8'h20, 8'h55, NVB_PM_RSVD, 0, 1'b0);
      rd_reg(NVB_REG_CTRL, q);
      chk(q & 8'h02, 8'h00);
   endtask

   // Start attempted on purpose while the flash is being programmed
   task automatic t_flash();
      fsp = 1'b1;
      prog(8'h30, 8'h99, NVB_PM_ATOMIC, 0, 1'b0);
      rd_reg(NVB_REG_CTRL, q);
      chk(q & 8'h02, 8'h00);
      fsp = 1'b0;
   endtask

   task automatic t_rst_busy();
      prog(8'h40, 8'h00, NVB_PM_ERASE, 0, 1'b0);
      srst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      srst_i = 1'b0;
      rd_reg(NVB_REG_CTRL, q);
      chk(q, 8'h12);
      wait_idle();
      rd_back(8'h40, 8'hff);
      wr_reg(NVB_REG_CTRL, 8'h20);
      srst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      srst_i = 1'b0;
      rd_reg(NVB_REG_CTRL, q);
      chk(q, 8'h00);
   endtask

   // Main sequence
   initial begin
      io = '0;
      srst_i = 1'b1;
      gie = 1'b0;
      fsp = 1'b0;
      repeat (20) @(negedge clk_i);
      srst_i = 1'b0;
      t_reset_vals();
      t_window();
      t_atomic();
      t_modes();
      t_flash();
      t_rst_busy();
      close_out();
   end
endmodule // nvb_ctrl_bench
